// >>> test_uart_pin_signal_control.sv
// self-checking bench for the pin level control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
    $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module test_uart_pin_signal_control;
    import upsc_pkg::*;
    typedef struct packed {
        logic [4:0] ctl;
        logic [7:0] gin;
        logic [4:0] exp;
    } upsc_row_t;
    // ctl {mcr1,efr7,cts_n,drive,host}, exp {rts_n,msr4,tx,oe,sda_rx}
    upsc_row_t rows [4] = '{'{5'h16, 8'hA5, 5'h06}, '{5'h0D, 8'h5A, 5'h10},
                            '{5'h08, 8'hFF, 5'h1D}, '{5'h13, 8'h3C, 5'h0E}};
    logic clk_sys = 1'b0, rst = 1'b0, if_sel_i2c = 1'b1, host_pull = 1'b0;
    logic [7:0] modem_control_register = 8'h00, gpio_in = 8'h00;
    logic [7:0] enhanced_feature_register = 8'h00;
    logic [7:0] interrupt_enable_register = 8'h00;
    upsc_gpio_cfg_t gpio_cfg = '0;
    logic [4:0] irq_clear = 5'h00, irq_pending;
    logic rx_data_avail = 1'b0, tx_space_avail = 1'b0, rx_error = 1'b0;
    logic rx_fifo_halt = 1'b0, rx_fifo_resume = 1'b0, cts_n = 1'b1;
    logic sda_drive_low = 1'b0, sda_rx, sda_wire, sda_out, sda_oe;
    logic irq_n_out, irq_n_oe, irq_wire, rts_n, tx_allowed;
    logic [7:0] modem_status_register, gpio_out, gpio_oe, gpio_read;
    int failures = 0, total_checks = 0, cycles = 0;
    wire [4:0] row_out = {rts_n, modem_status_register[4], tx_allowed,
                          sda_oe, sda_rx};
    upsc_top dut_u (.clk_sys, .rst, .if_sel_i2c, .modem_control_register,
        .enhanced_feature_register, .interrupt_enable_register, .gpio_cfg,
        .irq_clear, .rx_data_avail, .tx_space_avail, .rx_error,
        .rx_fifo_halt, .rx_fifo_resume, .cts_n, .sda_drive_low, .sda_rx,
        .sda_in(sda_wire), .sda_out, .sda_oe, .irq_n_out, .irq_n_oe,
        .irq_pending, .rts_n, .modem_status_register, .tx_allowed,
        .gpio_in, .gpio_out, .gpio_oe, .gpio_read);
    upsc_host_model host_u (.if_sel_i2c, .host_pull, .sda_out, .sda_oe,
        .irq_n_out, .irq_n_oe, .sda_wire, .irq_wire);
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // hang guard, far above the few dozen cycles the tests need
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        rst <= 1'b1; // a real edge at time zero fires the async reset
        tick(16);
        `CHK({rts_n, irq_pending, sda_rx}, 7'h41)
        @(posedge clk_sys) rst <= 1'b0;
        tick(3);
        `CHK(rts_n, 1'b1)
        foreach (rows[i]) begin
            @(posedge clk_sys);
            {modem_control_register[1], enhanced_feature_register[7], cts_n,
             sda_drive_low, host_pull} <= rows[i].ctl;
            gpio_in <= rows[i].gin;
            tick(2);
            `CHK(row_out, rows[i].exp)
            `CHK(gpio_read, rows[i].gin)
        end
        // halt is latched in the auto state but reaches rts_n only once auto mode is on
        @(posedge clk_sys) rx_fifo_halt <= 1'b1;
        @(posedge clk_sys) rx_fifo_halt <= 1'b0;
        tick(2);
        `CHK(rts_n, 1'b0)
        @(posedge clk_sys) enhanced_feature_register[6] <= 1'b1;
        rx_fifo_resume <= 1'b1;
        @(posedge clk_sys) rx_fifo_resume <= 1'b0;
        rx_fifo_halt <= 1'b1;
        @(posedge clk_sys) rx_fifo_halt <= 1'b0;
        tick(2);
        `CHK(rts_n, 1'b1)
        // clear all, then one enabled and four disabled sources
        @(posedge clk_sys) interrupt_enable_register <= 8'h01;
        irq_clear <= 5'h1F;
        @(posedge clk_sys) irq_clear <= 5'h00;
        tick(1);
        `CHK({irq_pending, irq_wire}, 6'h01)
        @(posedge clk_sys) rx_data_avail <= 1'b1;
        @(posedge clk_sys) rx_data_avail <= 1'b0;
        #1;
        `CHK({irq_pending, irq_wire}, 6'h02)
        @(posedge clk_sys) {tx_space_avail, rx_error} <= 2'h3;
        cts_n <= ~cts_n;
        gpio_in <= ~gpio_in;
        @(posedge clk_sys) {tx_space_avail, rx_error} <= 2'h0;
        tick(2);
        `CHK(irq_pending, 5'h1F)
        @(posedge clk_sys) irq_clear <= 5'h01;
        @(posedge clk_sys) irq_clear <= 5'h00;
        #1;
        `CHK({irq_pending, irq_n_oe, irq_wire}, 7'h79)
        // modem mode: pin 5 carries inverted dtr, pins 0..3 per config
        @(posedge clk_sys) gpio_cfg <= '{8'h0F, 8'hA5, 1'b1};
        modem_control_register[0] <= 1'b1;
        tick(1);
        `CHK({gpio_oe, gpio_out & gpio_oe}, 16'h2F05)
        `CHK(modem_status_register, 8'h20)
        @(posedge clk_sys) gpio_cfg <= '{8'hF0, 8'hA5, 1'b0};
        tick(1);
        `CHK({gpio_oe, gpio_out & gpio_oe}, 16'hF0A0)
        // second reset into spi mode; the board grounds the pin
        @(posedge clk_sys) rst <= 1'b1;
        if_sel_i2c <= 1'b0;
        sda_drive_low <= 1'b1;
        tick(2);
        `CHK({rts_n, irq_n_oe}, 2'h2)
        @(posedge clk_sys) rst <= 1'b0;
        tick(3);
        `CHK({sda_oe, sda_rx, sda_wire}, 3'h2)
        `CHK(irq_pending, 5'h00)
        tally_and_finish();
    end
endmodule
`default_nettype wire

// >>> upsc_host_model.sv
// far side model: board wires with pull-ups and the spi tie-off
`timescale 1ns/1ns
`default_nettype none
module upsc_host_model (
    input  wire logic if_sel_i2c,
    input  wire logic host_pull,
    input  wire logic sda_out,
    input  wire logic sda_oe,
    input  wire logic irq_n_out,
    input  wire logic irq_n_oe,
    output logic      sda_wire,
    output logic      irq_wire
);
    // pull-up wins unless a party sinks; spi boards ground the pin
    assign sda_wire = if_sel_i2c ? !(host_pull || (sda_oe && !sda_out))
                                 : 1'b0;
    assign irq_wire = (irq_n_oe && !irq_n_out) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// >>> upsc_irq_latch.sv
// sticky interrupt pending bits with enable gating
`timescale 1ns/1ns
`default_nettype none
module upsc_irq_latch (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire upsc_pkg::upsc_events_t   events,
    input  wire logic [4:0]               enable,
    input  wire logic [4:0]               clear,
    output logic      [4:0]               pending,
    output logic                          any_enabled
);
    import upsc_pkg::*;

    logic [4:0] pend_reg;
    logic [4:0] pend_next;
    logic [4:0] ev_vec;

    // set beats clear so an event in the clear cycle survives
    assign ev_vec    = events;
    assign pend_next = (pend_reg & ~clear) | ev_vec;

    // pending bits hold until software clears them
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend_reg <= 5'h00;
        end else begin
            pend_reg <= pend_next;
        end
    end

    assign pending     = pend_reg;
    // only enabled sources may reach the pin
    assign any_enabled = |(pend_reg & enable);
endmodule
`default_nettype wire

// >>> upsc_pin_monitor.sv
// concurrent checks on the pin level control ports
`timescale 1ns/1ns
`default_nettype none
module upsc_pin_monitor (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       if_sel_i2c,
    input wire logic [7:0] modem_control_register,
    input wire logic [7:0] enhanced_feature_register,
    input wire logic [7:0] interrupt_enable_register,
    input wire logic [4:0] irq_clear,
    input wire logic       rx_data_avail,
    input wire logic       cts_n,
    input wire logic       sda_drive_low,
    input wire logic       sda_oe,
    input wire logic       irq_n_oe,
    input wire logic [4:0] irq_pending,
    input wire logic       rts_n,
    input wire logic [7:0] modem_status_register,
    input wire logic       tx_allowed,
    input wire logic [7:0] gpio_in,
    input wire logic [7:0] gpio_read
);
    import upsc_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // the pin sinks only for pending bits that software enabled
    a_irq_enabled_only: assert property (
        irq_n_oe == |(irq_pending & interrupt_enable_register[4:0]))
        else $error("irq pin disagrees with enabled pending bits");
    // next-cycle checks start only from cycles out of reset, as the
    // flops loaded at the release edge still hold reset values
    a_rx_data_sets: assert property (!rst && rx_data_avail |=>
        irq_pending[IER_RX_DATA_BIT]) else $error("rx data not pending");
    // a pending bit may only drop through its clear
    a_pending_sticky: assert property (!rst |=>
        (irq_pending & $past(irq_pending & ~irq_clear))
        == $past(irq_pending & ~irq_clear)) else $error("pending lost");
    a_rts_sw_drive: assert property (
        !rst && !enhanced_feature_register[EFR_AUTO_RTS_BIT] |=>
        rts_n == !$past(modem_control_register[MCR_RTS_BIT]))
        else $error("rts_n does not follow software bit");
    // checked while reset is held, so no disable here
    a_reset_quiet: assert property (disable iff (1'b0)
        rst |-> rts_n && !irq_n_oe && irq_pending == 5'h00)
        else $error("outputs not idle in reset");
    a_sda_mode_drive: assert property (
        sda_oe == (if_sel_i2c && sda_drive_low)) else $error("sda drive");
    a_cts_status: assert property (!rst |=>
        modem_status_register[MSR_CTS_BIT] == !$past(cts_n))
        else $error("cts status bit wrong");
    a_tx_gate_cts: assert property (
        tx_allowed == (!enhanced_feature_register[EFR_AUTO_CTS_BIT]
        || modem_status_register[MSR_CTS_BIT])) else $error("tx gate");
    a_gpio_sample: assert property (!rst |=>
        gpio_read == $past(gpio_in)) else $error("gpio read stale");
    c_irq_asserted: cover property ($rose(irq_n_oe));
    c_rts_ready: cover property ($fell(rts_n));
    c_tx_blocked: cover property ($fell(tx_allowed));
endmodule
bind upsc_top upsc_pin_monitor mon_u (.clk_sys, .rst, .if_sel_i2c,
    .modem_control_register, .enhanced_feature_register,
    .interrupt_enable_register, .irq_clear, .rx_data_avail, .cts_n,
    .sda_drive_low, .sda_oe, .irq_n_oe, .irq_pending, .rts_n,
    .modem_status_register, .tx_allowed, .gpio_in, .gpio_read);
`default_nettype wire

// >>> upsc_pkg.sv
// shared constants and carrier types for the uart pin signal control block
package upsc_pkg;

    // modem control register bit positions
    localparam int MCR_RTS_BIT       = 1;
    localparam int MCR_DTR_BIT       = 0;
    // enhanced feature register bit positions
    localparam int EFR_AUTO_RTS_BIT  = 6;
    localparam int EFR_AUTO_CTS_BIT  = 7;
    // modem status register bit position of clear-to-send
    localparam int MSR_CTS_BIT       = 4;
    // interrupt enable bit positions, one per event class
    localparam int IER_RX_DATA_BIT   = 0;
    localparam int IER_TX_SPACE_BIT  = 1;
    localparam int IER_RX_ERR_BIT    = 2;
    localparam int IER_MODEM_BIT     = 3;
    localparam int IER_PIN_BIT       = 4;
    localparam int NUM_IRQ_SRC       = 5;
    // reset values
    localparam logic RTS_N_RESET     = 1'b1;
    localparam logic [7:0] GPIO_RESET = 8'h00;
    localparam logic [3:0] MODEM_PIN_RESET = 4'hF;
    localparam logic [2:0] CTS_SYNC_RESET  = 3'h7;

    // event pulses that feed the interrupt logic
    typedef struct packed {
        logic pin_change;
        logic modem_flag;
        logic rx_error;
        logic tx_space;
        logic rx_data;
    } upsc_events_t;

    // software view of the general pins
    typedef struct packed {
        logic [7:0] dir_out;     // 1 = pin driven by device
        logic [7:0] out_val;     // level to drive
        logic       modem_mode;  // pins 4..7 act as modem lines
    } upsc_gpio_cfg_t;

    // open-drain or two-way pin as three signals
    typedef struct packed {
        logic in;
        logic out;
        logic oe;
    } upsc_pin_t;

endpackage

// >>> upsc_top.sv
// pin level control: interrupt, request to send, data pin, general pins
//
// Contract
// - The interrupt pin is active-low open-drain and only enabled sources pull it low.
// - Pin changes, receive errors, receive data, transmit space and modem flags raise interrupts.
// - Writing one to modem control bit 1 drives request-to-send low while enhanced feature bit 6 is clear.
// - After reset request-to-send sits high until software or auto flow control moves it.
// - Request-to-send affects data flow only with enhanced feature bit 6 set.
// - Request-to-send low means data is ready for transfer, high means not.
// - The data pin is open-drain two-way in I2C mode and unused, grounded, in SPI mode.
// - General pins 0 to 3 are programmable and pins 4 to 7 may act as modem lines.
// - Clear-to-send shows in modem status bit 4 and gates transmit only with bit 7 set.
`timescale 1ns/1ns
`default_nettype none
module upsc_top (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    // host interface select, high = i2c
    input  wire logic                     if_sel_i2c,
    // register contents as written by the host
    input  wire logic [7:0]               modem_control_register,
    input  wire logic [7:0]               enhanced_feature_register,
    input  wire logic [7:0]               interrupt_enable_register,
    input  wire upsc_pkg::upsc_gpio_cfg_t gpio_cfg,
    input  wire logic [4:0]               irq_clear,
    // events from the uart core
    input  wire logic                     rx_data_avail,
    input  wire logic                     tx_space_avail,
    input  wire logic                     rx_error,
    input  wire logic                     rx_fifo_halt,
    input  wire logic                     rx_fifo_resume,
    // clear-to-send pin, active low
    input  wire logic                     cts_n,
    // bus data pin from the serial host engine
    input  wire logic                     sda_drive_low,
    output logic                          sda_rx,
    input  wire logic                     sda_in,
    output logic                          sda_out,
    output logic                          sda_oe,
    // interrupt pin, open drain
    output logic                          irq_n_out,
    output logic                          irq_n_oe,
    output logic      [4:0]               irq_pending,
    // request to send, active low
    output logic                          rts_n,
    // modem status and transmit gate
    output logic      [7:0]               modem_status_register,
    output logic                          tx_allowed,
    // general pins
    input  wire logic [7:0]               gpio_in,
    output logic      [7:0]               gpio_out,
    output logic      [7:0]               gpio_oe,
    output logic      [7:0]               gpio_read
);
    import upsc_pkg::*;

    logic         rts_auto_reg;
    logic         rts_auto_next;
    logic         rts_n_reg;
    logic         rts_n_next;
    logic [2:0]   cts_hist_reg;
    logic [3:0]   modem_in_reg;
    logic [7:0]   gpio_prev_reg;
    logic [7:0]   gpio_read_reg;
    logic         sda_rx_reg;
    logic         primed_reg;
    logic         auto_rts_en;
    logic         auto_cts_en;
    logic         sw_rts_active;
    logic         cts_active;
    logic         cts_changed;
    logic [3:0]   modem_in;
    logic         modem_changed;
    logic         pins_changed;
    logic [7:0]   modem_map;
    logic         modem_dtr_out;
    logic         irq_any;
    upsc_events_t events;

    // mode bits taken from the feature register
    assign auto_rts_en   = enhanced_feature_register[EFR_AUTO_RTS_BIT];
    assign auto_cts_en   = enhanced_feature_register[EFR_AUTO_CTS_BIT];
    assign sw_rts_active = modem_control_register[MCR_RTS_BIT];

    // auto mode: deassert at halt level, reassert at resume level
    assign rts_auto_next = rx_fifo_halt   ? 1'b0 :
                           rx_fifo_resume ? 1'b1 : rts_auto_reg;
    // low = data ready, only auto mode ties it to the fifo
    assign rts_n_next = auto_rts_en ? ~rts_auto_reg
                                    : ~sw_rts_active;

    // rts starts inactive; auto state starts ready to receive
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rts_n_reg    <= RTS_N_RESET;
            rts_auto_reg <= 1'b1;
        end else begin
            rts_n_reg    <= rts_n_next;
            rts_auto_reg <= rts_auto_next;
        end
    end
    assign rts_n = rts_n_reg;

    // cts history: newest sample in bit 0, used for edge detect
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cts_hist_reg <= CTS_SYNC_RESET;
        end else begin
            cts_hist_reg <= {cts_hist_reg[1:0], cts_n};
        end
    end
    assign cts_active  = ~cts_hist_reg[0];
    assign cts_changed = cts_hist_reg[0] ^ cts_hist_reg[1];
    // without auto cts the transmitter ignores the pin
    assign tx_allowed  = ~auto_cts_en | cts_active;

    // modem lines on pins 4..7 when in modem mode, active low
    assign modem_in = gpio_cfg.modem_mode ? ~gpio_in[7:4] : 4'h0;

    // modem input state and general pin sampling
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            modem_in_reg  <= 4'h0;
            gpio_prev_reg <= GPIO_RESET;
            gpio_read_reg <= GPIO_RESET;
            sda_rx_reg    <= 1'b1;
            primed_reg    <= 1'b0;
        end else begin
            primed_reg    <= 1'b1;
            modem_in_reg  <= modem_in;
            gpio_prev_reg <= gpio_in;
            gpio_read_reg <= gpio_in;
            sda_rx_reg    <= if_sel_i2c ? sda_in : 1'b1;
        end
    end

    // status: dsr bit 5, cts bit 4, ri bit 6, cd bit 7, cts change in bit 0, bits 1..3 zero
    assign modem_status_register = {modem_in_reg[2],            // cd
                                    modem_in_reg[3],            // ri
                                    modem_in_reg[0],            // dsr
                                    cts_active,
                                    1'b0,
                                    1'b0,
                                    1'b0,
                                    cts_changed};
    // auto cts keeps cts edges out of the modem interrupt, as the device self-gates
    assign modem_changed = (cts_changed & ~auto_cts_en) |
                           (|(modem_in ^ modem_in_reg));
    // only pins clear in gpio_cfg.dir_out count as input changes;
    // the first cycle after reset is skipped, since the history was
    // cleared and would report a change on every high pin
    assign pins_changed  = primed_reg &
                           (|((gpio_in ^ gpio_prev_reg) & ~gpio_cfg.dir_out));

    // event vector into the sticky latch
    assign events.rx_data    = rx_data_avail;
    assign events.tx_space   = tx_space_avail;
    assign events.rx_error   = rx_error;
    assign events.modem_flag = modem_changed;
    assign events.pin_change = pins_changed;

    upsc_irq_latch u_irq (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .events      (events),
        .enable      (interrupt_enable_register[4:0]),
        .clear       (irq_clear),
        .pending     (irq_pending),
        .any_enabled (irq_any)
    );

    // open drain: drive low only while an enabled source is pending
    assign irq_n_out = 1'b0;
    assign irq_n_oe  = irq_any;

    // i2c data pin: pull low only, never in spi mode
    assign sda_out = 1'b0;
    assign sda_oe  = if_sel_i2c & sda_drive_low;
    assign sda_rx  = sda_rx_reg;

    // dtr output on pin 5 in modem mode, active low, from mcr bit 0
    assign modem_dtr_out = ~modem_control_register[MCR_DTR_BIT];
    assign modem_map = {gpio_cfg.out_val[7],
                        gpio_cfg.out_val[6],
                        modem_dtr_out,
                        gpio_cfg.out_val[4],
                        gpio_cfg.out_val[3:0]};
    // in modem mode pins 4,6,7 are inputs and pin 5 an output
    assign gpio_out  = gpio_cfg.modem_mode ? modem_map
                                           : gpio_cfg.out_val;
    assign gpio_oe   = gpio_cfg.modem_mode ?
                       {2'h0, 1'b1, 1'b0, gpio_cfg.dir_out[3:0]}
                       : gpio_cfg.dir_out;
    assign gpio_read = gpio_read_reg;
endmodule
`default_nettype wire
